// File: ccr_serial_regs.v
// Purpose: serial control bank of a clock synthesizer
// Assumes: host drives the bus clock; sda is open drain
// Notes:   bytes 0 to 5 only, single-byte transfers only
`timescale 1ns/1ps
`include "ccr_defs.vh"
module ccr_serial_regs (
	// clock and reset
	input  wire       clk,
	input  wire       resetn,
	// serial management bus
	input  wire       scl,
	input  wire       sda_i,
	output reg        sda_o,
	output reg        sda_oe,
	// straps and power good
	input  wire       freq_strap_high,
	input  wire       freq_strap_mid,
	input  wire       freq_strap_low,
	input  wire       power_good,
	// power control pins, high when asserted
	input  wire       power_down_input,
	input  wire       processor_clock_stop_input,
	input  wire       legacy_bus_clock_stop_input,
	// register contents to the clock core
	output wire [7:0] freq_latch_mode_ctrl,
	output wire [7:0] source_spread_select_ctrl,
	output wire [7:0] ref_usb_pci_output_enables,
	output wire [7:0] upper_src_output_enables,
	output wire [7:0] lower_src_cpu_enables_spread,
	output wire [7:0] clock_request_routing
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	localparam [47:0] RST_ALL   = `CCR_RST_ALL;
	localparam [47:0] WMASK_ALL = `CCR_WMASK_ALL;
	localparam [7:0]  TGT_ADDR  = `CCR_TARGET_ADDR;

	wire [8:0]  pins_s;       // synchronised pins
	wire        scl_s;        // clean bus clock
	wire        sda_s;        // clean bus data
	wire        pgood_s;      // clean power good
	wire        pdown_s;      // clean power down
	wire        pstop_s;      // clean processor stop
	wire        lstop_s;      // clean legacy stop
	wire [2:0]  strap_s;      // clean straps, high first
	wire        scl_rise;     // bus clock rose
	wire        scl_fall;     // bus clock fell
	wire        start_det;    // start or repeated start
	wire        stop_det;     // stop condition
	wire [47:0] regs_flat;    // all bytes, byte 0 lowest
	wire [7:0]  read_byte;    // byte chosen by offset

	reg  [2:0]  state;        // transfer state
	reg  [1:0]  phase;        // which byte of the frame
	reg  [3:0]  bit_cnt;      // bits moved in this byte
	reg  [7:0]  shreg;        // incoming byte
	reg  [7:0]  tx;           // outgoing byte, msb first
	reg         rd_mode;      // address carried a read bit
	reg  [6:0]  offset;       // addressed byte
	reg  [7:0]  wdata;        // byte waiting to land
	reg         commit;       // one-cycle write strobe
	reg         pgood_q;      // power good, last cycle
	reg         strap_done;   // straps taken once
	reg         strap_take;   // one-cycle strap capture
	reg         combo_q;      // pin combination, last cycle
	wire        combo;        // all three pins asserted
	wire        mgmt_set;     // combination just formed
	wire        pd_clear;     // clear config in powerdown

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	// bus lines idle high: their flops reset high too, so no
	// false clock or data edge follows the release of reset
	ccr_sync #(
		.WIDTH   (9),
		.RST_VAL (9'h180)
	) u_sync (
		.clk      (clk),
		.resetn   (resetn),
		.async_in ({scl, sda_i, power_good, power_down_input,
		            processor_clock_stop_input,
		            legacy_bus_clock_stop_input,
		            freq_strap_high, freq_strap_mid,
		            freq_strap_low}),
		.sync_out (pins_s)
	);

	assign scl_s   = pins_s[8];
	assign sda_s   = pins_s[7];
	assign pgood_s = pins_s[6];
	assign pdown_s = pins_s[5];
	assign pstop_s = pins_s[4];
	assign lstop_s = pins_s[3];
	assign strap_s = pins_s[2:0];

	// ----------------------------------------
	// bus condition detect
	// ----------------------------------------
	// conditions come one cycle after the synchronised
	// levels, which the engine counts in its latency
	ccr_bus_cond u_cond (
		.clk       (clk),
		.resetn    (resetn),
		.scl_s     (scl_s),
		.sda_s     (sda_s),
		.scl_rise  (scl_rise),
		.scl_fall  (scl_fall),
		.start_det (start_det),
		.stop_det  (stop_det)
	);

	// ----------------------------------------
	// hardware events on byte 0
	// ----------------------------------------
	assign combo    = pdown_s & pstop_s & lstop_s;
	// edge, not level, so software may clear the bit later
	assign mgmt_set = combo & ~combo_q;
	// keep bit low means powerdown restores writable bits to reset values
	assign pd_clear = pdown_s &
		~regs_flat[`CCR_B0_PD_KEEP];
	// the clear lasts one cycle even while power down stays
	// high: it restores keep to one, which ends it

	// strap one-shot: later power good edges are ignored
	// straps must settle before power good rises; they are
	// read from the synchronised copy on the capture cycle
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pgood_q    <= 1'b0;
			strap_done <= 1'b0;
			strap_take <= 1'b0;
			combo_q    <= 1'b0;
		end else begin
			pgood_q    <= pgood_s;
			combo_q    <= combo;
			strap_take <= 1'b0;
			if (pgood_s && !pgood_q && !strap_done) begin
				strap_take <= 1'b1;
				strap_done <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// register bytes, one per generate entry
	// ----------------------------------------
	// one entry per byte; reset and mask words give each
	// byte its defaults and its writable bits, so a new
	// field needs only a change to the constants
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_reg
			localparam [7:0] RST = RST_ALL[g*8 +: 8];
			localparam [7:0] WM  = WMASK_ALL[g*8 +: 8];
			reg  [7:0] r;      // stored byte
			reg  [7:0] next_r; // value for next edge

			// merge clear, write and hardware sets
			always @* begin
				next_r = r;
				if (pd_clear) begin
					next_r = (r & ~WM) | (RST & WM);
				end
				if (commit && offset == g) begin
					// masked bits keep their value
					next_r = (next_r & ~WM) |
						(wdata & WM);
				end
				if (g == 0) begin
					if (strap_take) begin
						next_r[7:5] = strap_s;
					end
					// hardware set beats a clearing write
					if (mgmt_set) begin
						next_r[`CCR_B0_MGMT_EN] = 1'b1;
					end
				end
			end

			// defaults at power-up
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					r <= RST;
				end else begin
					r <= next_r;
				end
			end
			assign regs_flat[g*8 +: 8] = r;
		end
	endgenerate

	// field meanings, all but byte0 straps, mode enable and keep bit carried by the reset and mask words alone:
	// byte0 mode enable, storage source
	// byte1 pair route, spread profiles, source
	// byte1 legacy source select
	// byte2 and byte3 output enables
	// byte4 enables and spread enables
	// byte5 request enables and routes
	// bytes leave straight from their flops, no logic after
	// them, so the clock core sees clean levels
	assign freq_latch_mode_ctrl         = regs_flat[7:0];
	assign source_spread_select_ctrl    = regs_flat[15:8];
	assign ref_usb_pci_output_enables   = regs_flat[23:16];
	assign upper_src_output_enables     = regs_flat[31:24];
	assign lower_src_cpu_enables_spread = regs_flat[39:32];
	assign clock_request_routing        = regs_flat[47:40];

	// offset is checked below six before it is stored
	// the read byte is picked when the read ack ends; no
	// write can land later in the same frame
	assign read_byte = regs_flat[{offset[2:0], 3'b000} +: 8];

	// ----------------------------------------
	// transfer engine
	// ----------------------------------------
	// latency seen from the pins, in clk cycles:
	//   two sync flops, one edge-detect flop, one engine flop
	//   so sda_oe moves four cycles after the scl edge
	// the host must therefore keep scl low for six cycles
	// or more; a faster bus would see data change too late
	// states:
	//   idle  wait for a start, ignore clock edges
	//   rx    shift eight bits in on scl rise
	//   ack   hold sda low for one bit time
	//   tx    shift the read byte out on scl fall
	//   rack  let the host answer, back to idle on scl rise
	// phases walk addr, cmd, data, done within one frame
	// samples on scl rise, drives sda after scl fall so the
	// data line never moves while the clock is high
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state   <= `CCR_ST_IDLE;
			phase   <= `CCR_PH_ADDR;
			bit_cnt <= 4'h0;
			shreg   <= 8'h00;
			tx      <= 8'h00;
			rd_mode <= 1'b0;
			offset  <= 7'h00;
			wdata   <= 8'h00;
			commit  <= 1'b0;
			sda_o   <= 1'b0;
			sda_oe  <= 1'b0;
		end else begin
			commit <= 1'b0;
			sda_o  <= 1'b0; // open drain: only ever pulls low
			if (stop_det) begin
				// stop aborts; an unacked byte never lands
				state  <= `CCR_ST_IDLE;
				sda_oe <= 1'b0;
			end else if (start_det) begin
				// repeated start keeps the stored offset
				state   <= `CCR_ST_RX;
				phase   <= `CCR_PH_ADDR;
				bit_cnt <= 4'h0;
				sda_oe  <= 1'b0;
			end else begin
				case (state)
				`CCR_ST_IDLE: begin
					// only a start leaves idle, handled above
					sda_oe <= 1'b0;
				end
				`CCR_ST_RX: begin
					if (scl_rise && bit_cnt != 4'h8) begin
						shreg   <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						if (phase == `CCR_PH_ADDR) begin
							if (shreg[7:1] == TGT_ADDR[7:1]) begin
								rd_mode <= shreg[0];
								sda_oe  <= 1'b1;
								state   <= `CCR_ST_ACK;
							end else begin
								state <= `CCR_ST_IDLE;
							end
						end else if (phase == `CCR_PH_CMD) begin
							// block mode and far offsets get no ack
							if (shreg[`CCR_CMD_SINGLE] &&
								shreg[6:0] < `CCR_NUM_REGS) begin
								offset <= shreg[6:0];
								sda_oe <= 1'b1;
								state  <= `CCR_ST_ACK;
							end else begin
								state <= `CCR_ST_IDLE;
							end
						end else if (phase == `CCR_PH_DATA) begin
							wdata  <= shreg;
							sda_oe <= 1'b1;
							state  <= `CCR_ST_ACK;
						end else begin
							// a second data byte is refused
							state <= `CCR_ST_IDLE;
						end
					end
				end
				`CCR_ST_ACK: begin
					if (scl_fall) begin
						// ack clock over: release or send data
						sda_oe <= 1'b0;
						state  <= `CCR_ST_RX;
						if (phase == `CCR_PH_ADDR) begin
							phase <= `CCR_PH_CMD;
							if (rd_mode) begin
								tx      <= {read_byte[6:0], 1'b0};
								sda_oe  <= ~read_byte[7];
								bit_cnt <= 4'h1;
								state   <= `CCR_ST_TX;
							end
						end else if (phase == `CCR_PH_CMD) begin
							phase <= `CCR_PH_DATA;
						end else begin
							phase  <= `CCR_PH_DONE;
							commit <= 1'b1;
						end
					end
				end
				`CCR_ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							// let the host answer
							sda_oe <= 1'b0;
							state  <= `CCR_ST_RACK;
						end else begin
							sda_oe  <= ~tx[7];
							tx      <= {tx[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				`CCR_ST_RACK: begin
					// single byte only: ack or nack, back to idle on scl rise
					if (scl_rise) begin
						state <= `CCR_ST_IDLE;
					end
				end
				default: begin
					state  <= `CCR_ST_IDLE;
					sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end

endmodule // ccr_serial_regs

// File: ccr_defs.vh
// Purpose: constants of the clock synthesizer control bank
// Assumes: byte-serial access only, offsets 0 to 5
// Notes:   reset values leave strap bits at 0 until latched
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// ----------------------------------------
// bus address and command layout
// ----------------------------------------
`define CCR_TARGET_ADDR 8'hd2
`define CCR_CMD_SINGLE  7
`define CCR_NUM_REGS    7'h06

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCR_OFF_FREQ_LATCH_MODE  7'h00
`define CCR_OFF_SOURCE_SPREAD    7'h01
`define CCR_OFF_REF_USB_PCI_OE   7'h02
`define CCR_OFF_UPPER_SRC_OE     7'h03
`define CCR_OFF_LOWER_SRC_CPU    7'h04
`define CCR_OFF_CLOCK_REQUEST    7'h05

// ----------------------------------------
// byte 0 fields
// ----------------------------------------
`define CCR_B0_STRAP_HI   7
`define CCR_B0_STRAP_LO   5
`define CCR_B0_MGMT_EN    4
`define CCR_B0_STORE_SEL  1
`define CCR_B0_PD_KEEP    0

// ----------------------------------------
// reset values, byte 5 down to byte 0
// ----------------------------------------
`define CCR_RST_ALL 48'h00_ff_ff_ff_03_01

// ----------------------------------------
// writable bits, byte 5 down to byte 0
// ----------------------------------------
`define CCR_WMASK_ALL 48'hff_ff_fd_ff_e1_13

// ----------------------------------------
// transfer states and byte phases
// ----------------------------------------
`define CCR_ST_IDLE 3'h0
`define CCR_ST_RX   3'h1
`define CCR_ST_ACK  3'h2
`define CCR_ST_TX   3'h3
`define CCR_ST_RACK 3'h4
`define CCR_PH_ADDR 2'h0
`define CCR_PH_CMD  2'h1
`define CCR_PH_DATA 2'h2
`define CCR_PH_DONE 2'h3

`endif

// File: ccr_sync.v
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are slow compared with clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module ccr_sync #(
	parameter             WIDTH   = 9,
	// reset level of each bit, the idle level of its pin
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	// clock and reset
	input  wire             clk,
	input  wire             resetn,
	// pin side and clean side
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			reg meta;  // first stage, read by stage two only
			reg clean; // second stage
			// ----------------------------------------
			// two flops per bit
			// ----------------------------------------
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					meta  <= RST_VAL[g];
					clean <= RST_VAL[g];
				end else begin
					meta  <= async_in[g];
					clean <= meta;
				end
			end
			assign sync_out[g] = clean;
		end
	endgenerate

endmodule // ccr_sync

// File: ccr_bus_cond.v
// Purpose: find clock edges, start and stop on the serial bus
// Assumes: scl and sda already synchronised to clk
// Notes:   all outputs are one-cycle pulses
`timescale 1ns/1ps
module ccr_bus_cond (
	// clock and reset
	input  wire clk,
	input  wire resetn,
	// synchronised bus lines
	input  wire scl_s,
	input  wire sda_s,
	// bus events
	output reg  scl_rise,
	output reg  scl_fall,
	output reg  start_det,
	output reg  stop_det
);

	reg scl_q; // previous bus clock level
	reg sda_q; // previous bus data level

	// ----------------------------------------
	// edge and condition detect
	// ----------------------------------------
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			scl_rise  <= 1'b0;
			scl_fall  <= 1'b0;
			start_det <= 1'b0;
			stop_det  <= 1'b0;
		end else begin
			scl_q     <= scl_s;
			sda_q     <= sda_s;
			scl_rise  <= scl_s & ~scl_q;
			scl_fall  <= ~scl_s & scl_q;
			// data moving while clock high is a condition
			start_det <= scl_s & scl_q & sda_q & ~sda_s;
			stop_det  <= scl_s & scl_q & ~sda_q & sda_s;
		end
	end

endmodule // ccr_bus_cond

// File: ccr_chk.sv
// Purpose: timing and value checks at the bank's ports
// Assumes: bus pins pass two sync flops inside the bank
// Notes:   windows allow for that sync delay
`timescale 1ns/1ps
module ccr_chk (
	// clock and reset
	input wire       clk,
	input wire       resetn,
	// bus and power pins
	input wire       scl,
	input wire       sda_o,
	input wire       sda_oe,
	input wire       power_good,
	input wire       power_down_input,
	input wire       processor_clock_stop_input,
	input wire       legacy_bus_clock_stop_input,
	// register bytes
	input wire [7:0] freq_latch_mode_ctrl,
	input wire [7:0] source_spread_select_ctrl,
	input wire [7:0] ref_usb_pci_output_enables,
	input wire [7:0] upper_src_output_enables,
	input wire [7:0] lower_src_cpu_enables_spread,
	input wire [7:0] clock_request_routing
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	wire [7:0]  b0 = freq_latch_mode_ctrl;    // short alias
	wire [7:0]  b3 = upper_src_output_enables; // short alias
	wire [7:0]  b5 = clock_request_routing;    // short alias
	wire [39:0] hi = {b5, lower_src_cpu_enables_spread, b3,
		ref_usb_pci_output_enables, source_spread_select_ctrl};
	wire        all3 = power_down_input & processor_clock_stop_input &
		legacy_bus_clock_stop_input;
	reg  [3:0]  pd_age;      // cycles since power down, saturating
	reg  [3:0]  oe_age;      // cycles since sda pulled, saturating
	reg  [2:0]  strap_prev;  // last strap field
	reg         strap_moved; // straps already latched once

	// ages let the byte check excuse the power-down clear path
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pd_age      <= 4'hf;
			oe_age      <= 4'hf;
			strap_prev  <= 3'h0;
			strap_moved <= 1'b0;
		end else begin
			pd_age      <= power_down_input ? 4'h0 :
				pd_age + {3'h0, pd_age != 4'hf};
			oe_age      <= sda_oe ? 4'h0 : oe_age + {3'h0, oe_age != 4'hf};
			strap_prev  <= b0[7:5];
			strap_moved <= strap_moved | (strap_prev != b0[7:5]);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_oe_scl_low;
		$changed(sda_oe) |-> !scl && !$past(scl, 2);
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low)
		else $error("sda enable moved while scl high");
	property p_oe_hold;
		$rose(sda_oe) |-> sda_oe [*6];
	endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("sda pull shorter than a bit time");
	property p_open_drain;
		sda_oe |-> !sda_o;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("sda driven high");
	property p_bus_write;
		$changed(hi) && pd_age > 4'h9 |-> oe_age < 4'h6;
	endproperty
	a_bus_write: assert property (p_bus_write)
		else $error("byte changed away from a data ack");
	property p_strap_cause;
		$changed(b0[7:5]) |-> power_good && $past(power_good, 3);
	endproperty
	a_strap_cause: assert property (p_strap_cause)
		else $error("strap bits moved without power good");
	property p_strap_once;
		$changed(b0[7:5]) |-> !strap_moved;
	endproperty
	a_strap_once: assert property (p_strap_once)
		else $error("strap bits latched twice");
	property p_reserved;
		b0[3:2] == 2'h0 && source_spread_select_ctrl[4:1] == 4'h1 && b3[1];
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bit off its default");
	property p_mgmt_set;
		$rose(all3) && b0[0] |-> ##[2:6] b0[4];
	endproperty
	a_mgmt_set: assert property (p_mgmt_set)
		else $error("mode bit not set by pins");
	property p_pd_clear;
		$rose(power_down_input) && !b0[0] |->
			##[3:8] (b3 == 8'hff && b5 == 8'h00);
	endproperty
	a_pd_clear: assert property (p_pd_clear)
		else $error("power down did not clear bytes");
endmodule // ccr_chk

// File: ccr_host.sv
// Purpose: behavioural bus host on the far side of the bank
// Assumes: sda has a pull-up; host pulls low only
// Notes:   scl low 240 ns, high 80 ns, period 320 ns
`timescale 1ns/1ps
module ccr_host (
	// bus
	output logic scl,
	output logic sda_pull,
	input  wire  sda
);
	// idle bus: both lines released
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// one bit: change data mid low, sample before fall
	task automatic bitx(input logic b, output logic r);
		#80 sda_pull = ~b;
		#160 scl = 1'b1;
		#80 r = sda;
		scl = 1'b0;
	endtask
	// start or repeated start: sda falls with scl high
	task automatic sta();
		#80 sda_pull = 1'b0;
		#160 scl = 1'b1;
		#160 sda_pull = 1'b1;
		#160 scl = 1'b0;
	endtask
	// stop: sda rises with scl high
	task automatic sto();
		#80 sda_pull = 1'b1;
		#160 scl = 1'b1;
		#160 sda_pull = 1'b0;
		#320;
	endtask
	// byte out msb first, then the target's ack bit
	task automatic tx(input logic [7:0] v, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(v[i], r);
		bitx(1'b1, r);
		a = ~r;
	endtask
	// byte write, or abort after n data bits
	task automatic wr(input logic [7:0] a, c, d, input int n,
		output logic [2:0] ak);
		logic r;
		#7;
		sta();
		tx(a, ak[2]);
		tx(c, ak[1]);
		ak[0] = 1'b0;
		if (n == 8) tx(d, ak[0]);
		else for (int i = 0; i < n; i++) bitx(d[7-i], r);
		sto();
	endtask
	// byte read ending in a not-acknowledge
	task automatic rd(input logic [7:0] c, output logic [7:0] v,
		output logic [2:0] ak);
		logic r;
		#7;
		sta();
		tx(8'hd2, ak[2]);
		tx(c, ak[1]);
		sta();
		tx(8'hd3, ak[0]);
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			v[i] = r;
		end
		bitx(1'b1, r);
		sto();
	endtask
endmodule // ccr_host

// File: tb_top.sv
// Purpose: self-checking bench of the serial control bank
// Assumes: host model drives the bus at its own phase
// Notes:   random bytes from a fixed seed plus corner cases
`timescale 1ns/1ps
module tb_top;
	logic       clk = 1'b0;    // 25 MHz
	logic       resetn = 1'b0; // held 5 cycles
	logic [2:0] strap = 3'h0;  // strap pins high..low
	logic       pgood = 1'b0;  // power good
	logic [2:0] pwr = 3'h0;    // down, cpu stop, legacy stop
	logic       scl;           // bus clock from host
	logic       pull;          // host pulls sda low
	wire        sda_o;         // target data, always low
	wire        sda_oe;        // target pulls sda low
	wire  [7:0] b [0:5];       // register bytes seen
	logic [7:0] m [0:5];       // register bytes expected
	int         failures = 0;
	int         n_checks = 0;
	wire        sda = ~(pull | (sda_oe & ~sda_o)); // pull-up

	always #20 clk = ~clk;

	ccr_host host (.scl(scl), .sda_pull(pull), .sda(sda));
	ccr_serial_regs uut (.clk(clk), .resetn(resetn), .scl(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.freq_strap_high(strap[2]), .freq_strap_mid(strap[1]),
		.freq_strap_low(strap[0]), .power_good(pgood),
		.power_down_input(pwr[2]), .processor_clock_stop_input(pwr[1]),
		.legacy_bus_clock_stop_input(pwr[0]),
		.freq_latch_mode_ctrl(b[0]), .source_spread_select_ctrl(b[1]),
		.ref_usb_pci_output_enables(b[2]),
		.upper_src_output_enables(b[3]),
		.lower_src_cpu_enables_spread(b[4]),
		.clock_request_routing(b[5]));

	// power-up value of each byte
	function automatic logic [7:0] rst(input int i);
		case (i)
			0: rst = 8'h01;
			1: rst = 8'h03;
			5: rst = 8'h00;
			default: rst = 8'hff;
		endcase
	endfunction
	// bits a bus write may change; straps and reserved stay
	function automatic logic [7:0] wm(input int i);
		case (i)
			0: wm = 8'h13;
			1: wm = 8'he1;
			3: wm = 8'hfd;
			default: wm = 8'hff;
		endcase
	endfunction
	task automatic chk(input logic [7:0] seen, exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cmp_all();
		for (int i = 0; i < 6; i++) chk(b[i], m[i], "byte");
	endtask
	// write; model follows only a fully acknowledged write
	task automatic wr(input logic [7:0] a, c, d, input int n,
		input logic [2:0] e);
		logic [2:0] ak;
		int         o;
		o = c[6:0];
		@(posedge clk); // host moves its lines just after an edge
		host.wr(a, c, d, n, ak);
		chk({5'h0, ak}, {5'h0, e}, "write acks");
		if (e == 3'b111) m[o] = (m[o] & ~wm(o)) | (d & wm(o));
		cmp_all();
	endtask
	task automatic rd(input int o);
		logic [2:0] ak;
		logic [7:0] v;
		@(posedge clk); // keep host edges off the sampling edge
		host.rd({1'b1, o[6:0]}, v, ak);
		chk({5'h0, ak}, 8'h07, "read acks");
		chk(v, m[o], "read data");
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// watchdog well past the expected run of under 1 ms
	initial begin
		#2000000;
		failures++;
		complete_run();
	end

	initial begin
		int         o;
		logic [7:0] d;
		void'($urandom(90324));
		strap <= 3'($urandom % 7 + 1);
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 6; i++) m[i] = rst(i);
		cmp_all();
		pgood <= 1'b1;
		repeat (12) @(posedge clk);
		m[0][7:5] = strap;
		cmp_all();
		// later power good edges must not relatch
		strap <= ~strap;
		pgood <= 1'b0;
		repeat (4) @(posedge clk);
		pgood <= 1'b1;
		repeat (12) @(posedge clk);
		cmp_all();
		// every writable bit set then cleared, read back each time
		for (int i = 0; i < 6; i++) begin
			wr(8'hd2, {1'b1, 7'(i)}, 8'hff, 8, 3'b111);
			rd(i);
			wr(8'hd2, {1'b1, 7'(i)}, 8'h00, 8, 3'b111);
			rd(i);
		end
		repeat (8) begin
			o = $urandom % 6;
			d = 8'($urandom);
			wr(8'hd2, {1'b1, 7'(o)}, d, 8, 3'b111);
			rd(o);
		end
		// refusals and an abort leave the bank unchanged
		wr(8'hd4, 8'h80, 8'h00, 8, 3'b000);
		wr(8'hd2, 8'h02, 8'h00, 8, 3'b100);
		wr(8'hd2, 8'h86, 8'h00, 8, 3'b100);
		wr(8'hd2, 8'h85, ~m[5], 4, 3'b110);
		// pins set management mode
		wr(8'hd2, 8'h80, 8'h01, 8, 3'b111);
		@(posedge clk);
		pwr <= 3'b111;
		repeat (4) @(posedge clk);
		pwr <= 3'b000;
		repeat (8) @(posedge clk);
		m[0][4] = 1'b1;
		cmp_all();
		// keep bit clear: power down restores writable bits
		wr(8'hd2, 8'h80, 8'h10, 8, 3'b111);
		@(posedge clk);
		pwr <= 3'b100;
		repeat (12) @(posedge clk);
		pwr <= 3'b000;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 6; i++) m[i] = (m[i] & ~wm(i)) | (rst(i) & wm(i));
		cmp_all();
		complete_run();
	end
endmodule // tb_top

bind ccr_serial_regs ccr_chk chk_i (.clk(clk), .resetn(resetn),
	.scl(scl), .sda_o(sda_o), .sda_oe(sda_oe), .power_good(power_good),
	.power_down_input(power_down_input),
	.processor_clock_stop_input(processor_clock_stop_input),
	.legacy_bus_clock_stop_input(legacy_bus_clock_stop_input),
	.freq_latch_mode_ctrl(freq_latch_mode_ctrl),
	.source_spread_select_ctrl(source_spread_select_ctrl),
	.ref_usb_pci_output_enables(ref_usb_pci_output_enables),
	.upper_src_output_enables(upper_src_output_enables),
	.lower_src_cpu_enables_spread(lower_src_cpu_enables_spread),
	.clock_request_routing(clock_request_routing));
